//--- logic/nct_pkg.sv
// Purpose : Shared constants for the board-connection NAND chain test
// Assumes : Chain positions are zero-based indices into the chain pin vector
// Notes   : Position n of the printed order sits at index n-1

package nct_pkg;

    // ------------------------------------------------------------
    // Chain geometry
    // ------------------------------------------------------------
    localparam int unsigned CHAIN_LEN = 49;  // Chain inputs, positions 1..49

    // ------------------------------------------------------------
    // Chain positions (index = position - 1)
    // ------------------------------------------------------------
    localparam int unsigned POS_P6_TRANSMIT_CLOCK_IN = 0;   // Position 1, head of chain
    localparam int unsigned POS_P6_TRANSMIT_ENABLE   = 1;   // Position 2
    localparam int unsigned POS_P6_TRANSMIT_ERROR    = 2;   // Position 3
    localparam int unsigned POS_P7_RECEIVE_CLOCK     = 24;  // Position 25
    localparam int unsigned POS_P7_RECEIVE_VALID     = 25;  // Position 26
    localparam int unsigned POS_P7_RECEIVE_ERROR     = 26;  // Position 27
    localparam int unsigned POS_P7_CARRIER_SENSE     = 27;  // Position 28
    localparam int unsigned POS_P7_RECEIVE_BIT3      = 28;  // Position 29
    localparam int unsigned POS_P7_RECEIVE_BIT0      = 31;  // Position 32
    localparam int unsigned POS_PORT4_LED_A          = 32;  // Position 33, strap
    localparam int unsigned POS_PORT4_LED_B          = 33;  // Position 34
    localparam int unsigned POS_PORT3_LED_A          = 34;  // Position 35
    localparam int unsigned POS_GPIO1                = 36;  // Position 37
    localparam int unsigned POS_PORT2_LED_A          = 37;  // Position 38, strap
    localparam int unsigned POS_PORT2_LED_B          = 38;  // Position 39, strap
    localparam int unsigned POS_WAKE_EVENT_LOW       = 39;  // Position 40
    localparam int unsigned POS_RESET_LOW            = 40;  // Position 41
    localparam int unsigned POS_SERIAL_MGMT_OUT      = 41;  // Position 42
    localparam int unsigned POS_SERIAL_MGMT_IN       = 42;  // Position 43
    localparam int unsigned POS_SERIAL_SELECT_LOW    = 43;  // Position 44
    localparam int unsigned POS_SERIAL_CLOCK         = 44;  // Position 45
    localparam int unsigned POS_PORT5_LED_A          = 45;  // Position 46
    localparam int unsigned POS_PORT1_LED_B          = 48;  // Position 49, tail of chain

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       RST_OUT_LOW    = 1'h1;  // Interrupt pin idles high
    localparam logic       RST_TEST_MODE  = 1'h0;  // Normal function after reset
    localparam logic       RST_STRAP_DONE = 1'h0;  // Straps not yet caught
    localparam logic [2:0] RST_STRAPS     = 3'h0;  // Caught strap value

endpackage : nct_pkg

//--- logic/nct_nand_stage.sv
// Purpose : One two-input NAND stage of the board test chain
// Assumes : Purely combinational, no clock
// Notes   : Instanced once per chain input

`timescale 1ns/10ps
`default_nettype none

module nct_nand_stage (
    // Stage inputs
    input  wire logic prev_i,  // Level from the deeper stage
    input  wire logic pin_i,   // Chain input pin
    // Stage output
    output logic      y_o      // NAND of both
);

    // ------------------------------------------------------------
    // Gate
    // ------------------------------------------------------------
    assign y_o = ~(prev_i & pin_i);

endmodule : nct_nand_stage

`default_nettype wire

//--- logic/nct_chain_test.sv
// Purpose : NAND chain board-connection test muxed onto the interrupt pin
// Assumes : Chain pins and straps are synchronous to mclk_i
// Notes   : Output is registered, so it follows the pins one cycle later

`timescale 1ns/10ps
`default_nettype none

module nct_chain_test #(
    parameter logic [2:0]  TEST_STRAP_CODE = 3'h7,  // Strap value selecting test mode
    parameter int unsigned CHAIN_LEN       = nct_pkg::CHAIN_LEN
) (
    // Clock and reset
    input  wire logic                 mclk_i,           // 10 MHz system clock
    input  wire logic                 rst_b_i,          // Asynchronous reset, active low
    // Chain pins, index = position - 1
    input  wire logic [CHAIN_LEN-1:0] chain_pins_i,     // Pin levels as seen at the pads
    // Normal interrupt source
    input  wire logic                 normal_irq_low_i, // Interrupt level in normal function
    // Pin side
    output logic                      interrupt_out_low_o, // Interrupt pin level
    output logic                      test_mode_o          // Chain test mode active
);

    // ------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------
    logic [CHAIN_LEN-1:0] stage_y;     // Stage outputs, deepest first
    logic                 chain_level; // Tail level, high when all pins high

    // Deepest stage sees a constant high, so every stage can flip the tail
    // Pin order comes from the index map alone, so a swapped pad shows up
    // on the board as a missing toggle rather than as a wrong level here
    genvar g;
    generate
        // Head and link stages differ only in what feeds prev_i
        for (g = 0; g < CHAIN_LEN; g++) begin : g_stage
            if (g == 0) begin : g_head
                nct_nand_stage u_stage (
                    .prev_i (1'h1),
                    .pin_i  (chain_pins_i[g]),
                    .y_o    (stage_y[g])
                );
            end else begin : g_link
                nct_nand_stage u_stage (
                    .prev_i (stage_y[g-1]),
                    .pin_i  (chain_pins_i[g]),
                    .y_o    (stage_y[g])
                );
            end
        end
    endgenerate

    // With all pins high the tail alternates per stage, so fix its sense here
    // Odd length needs the flip, an even length does not
    localparam logic TAIL_FLIP = (CHAIN_LEN % 2) == 1;
    assign chain_level = stage_y[CHAIN_LEN-1] ^ TAIL_FLIP;

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    logic       strap_done;      // Straps caught since reset release
    logic [2:0] straps;          // Caught {port2_led_b, port2_led_a, port4_led_a}
    logic       test_mode;       // Chain owns the interrupt pin
    logic       next_strap_done;
    logic [2:0] next_straps;
    logic       next_test_mode;
    logic [2:0] strap_now;       // Live strap levels

    // Straps share pads with chain positions 33, 38 and 39
    // Limitation: straps moving across release give an arbitrary mode
    assign strap_now = {chain_pins_i[nct_pkg::POS_PORT2_LED_B],
                        chain_pins_i[nct_pkg::POS_PORT2_LED_A],
                        chain_pins_i[nct_pkg::POS_PORT4_LED_A]};

    // Catch straps once, on the first edge after release
    // Straps are never re-read, so later pin activity cannot flip the mode
    always_comb begin
        next_strap_done = strap_done;
        next_straps     = straps;
        next_test_mode  = test_mode;
        if (!strap_done) begin // Only the first edge counts
            next_strap_done = 1'h1;
            next_straps     = strap_now;
            next_test_mode  = (strap_now == TEST_STRAP_CODE);
        end
    end

    // Reset loads constants only; straps are sampled after release
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_done <= nct_pkg::RST_STRAP_DONE;
            straps     <= nct_pkg::RST_STRAPS;
            test_mode  <= nct_pkg::RST_TEST_MODE;
        end else begin
            strap_done <= next_strap_done;
            straps     <= next_straps;
            test_mode  <= next_test_mode;
        end
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    // Registered so the pin never shows the ripple along the chain
    // Trade-off: board test logic waits one cycle per step
    logic next_out_low; // Next interrupt pin level

    // Mux chain or normal source; register costs one cycle of latency
    always_comb begin
        if (test_mode) begin
            next_out_low = chain_level;
        end else begin
            next_out_low = normal_irq_low_i;
        end
    end

    // Both pin outputs come straight from flops
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_out_low_o <= nct_pkg::RST_OUT_LOW;
            test_mode_o         <= nct_pkg::RST_TEST_MODE;
        end else begin
            interrupt_out_low_o <= next_out_low;
            test_mode_o         <= next_test_mode;
        end
    end

    // ------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------
    // Helpers only feed the checks below, never the pin logic
    logic [CHAIN_LEN-1:0] ones;        // All pins high
    logic [CHAIN_LEN-1:0] low_mask;    // Pins currently low
    logic [CHAIN_LEN-1:0] low_next;    // Low mask plus one, carry dropped
    logic                 prefix_low;  // Low pins form a head-first prefix
    assign ones       = '1;
    assign low_mask   = ~chain_pins_i;
    assign low_next   = low_mask + {{(CHAIN_LEN-1){1'b0}}, 1'b1};
    // A mask of the form 0..01..1 clears itself when one is added
    assign prefix_low = (low_next & low_mask) == '0;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Checks assume the board holds each pin level for at least one edge

    // Both outputs still sit at their idle reset levels when the first edge out of reset samples them
    a_release_idle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (rst_b_i && !strap_done) |-> !test_mode_o && interrupt_out_low_o)
        else $error("outputs not idle on first edge after reset");

    // Straps are judged on the first edge that is out of reset
    a_mode_entry: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (rst_b_i && !strap_done) |=> test_mode_o == ($past(strap_now) == TEST_STRAP_CODE))
        else $error("test mode does not match caught straps");

    // Later strap moves must not disturb the mode
    a_mode_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        strap_done ##1 strap_done |-> $stable(test_mode_o))
        else $error("test mode changed after capture");

    // Once caught, the strap copy stays put until the next reset
    a_strap_kept: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        strap_done |=> strap_done && $stable(straps))
        else $error("strap copy changed after capture");

    // All inputs high reads high, the start point of every sweep
    a_all_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (test_mode && chain_pins_i == ones) |=> interrupt_out_low_o)
        else $error("all inputs high did not give output high");

    // First lowered input pulls the pin low
    a_first_fall: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (test_mode && chain_pins_i == ones) ##1
        (test_mode && chain_pins_i == (ones << 1)) |=> !interrupt_out_low_o && $past(interrupt_out_low_o))
        else $error("first input low did not drive output low");

    // Second lowered input lifts the pin again
    a_second_rise: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (test_mode && chain_pins_i == (ones << 1)) ##1
        (test_mode && chain_pins_i == (ones << 2)) |=> interrupt_out_low_o && !$past(interrupt_out_low_o))
        else $error("second input low did not drive output high");

    // Every further prefix step flips the pin, which is what
    // the board counts on to find an open pad
    a_step_toggle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (test_mode && prefix_low) ##1
        (test_mode && prefix_low && $countones(low_mask) == $countones($past(low_mask)) + 1)
        |=> interrupt_out_low_o != $past(interrupt_out_low_o))
        else $error("chain step did not toggle output");

    // Pin sense follows the parity of the lowered prefix
    a_prefix_parity: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (test_mode && prefix_low) |=> interrupt_out_low_o == (($countones($past(low_mask)) % 2) == 0))
        else $error("output sense wrong for lowered prefix");

    // Fully lowered chain ends at the odd-length level
    a_all_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (test_mode && chain_pins_i == '0) |=> interrupt_out_low_o == !TAIL_FLIP)
        else $error("all inputs low gives wrong output");

    // Outside test mode the normal source owns the pin
    // and the chain pins may do anything without effect
    a_normal_pass: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (rst_b_i && !test_mode) |=> interrupt_out_low_o == $past(normal_irq_low_i))
        else $error("normal interrupt not passed outside test mode");

endmodule : nct_chain_test

`default_nettype wire

//--- verif/nct_board_model.sv
// Purpose : Board test logic that sweeps the NAND chain inputs low in order
// Assumes : Interrupt pin settles within one cycle of a pin change
// Notes   : Fault judging is only valid with a pace of two cycles or more
`timescale 1ns/10ps
`default_nettype none
module nct_board_model #(
    parameter int unsigned N = 49  // Chain inputs
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    // Control from the bench
    input  wire logic         start_i,   // Begin a new sweep
    input  wire logic [1:0]   pace_i,    // Cycles between steps
    input  wire logic         obs_low_i, // Interrupt pin as seen on the board
    // Board side
    output logic [N-1:0]      pins_o,    // Chain input levels
    output logic              done_o,    // Sweep finished
    output logic              fault_o    // Some step gave no toggle
);
    int unsigned idx;   // Next pin to lower
    int unsigned cnt;   // Pace counter
    logic        last;  // Pin level seen at the previous step
    // ------------------------------------------------------------
    // Sweep sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_o  <= '1;
            idx     <= N;
            cnt     <= 0;
            last    <= 1'b0;
            done_o  <= 1'b1;
            fault_o <= 1'b0;
        end else if (start_i) begin
            pins_o  <= '1;
            idx     <= 0;
            cnt     <= 0;
            last    <= 1'b0;  // All-high output must read 1
            done_o  <= 1'b0;
            fault_o <= 1'b0;
        end else if (!done_o) begin
            if (cnt + 1 < pace_i) begin
                cnt <= cnt + 1;
            end else begin
                cnt <= 0;
                // No toggle since last step marks the pin faulty
                if (pace_i > 1 && obs_low_i == last) fault_o <= 1'b1;
                last <= obs_low_i;
                // Earlier pins stay low, next one lowered
                if (idx < N) pins_o[idx] <= 1'b0;
                idx    <= idx + 1;
                done_o <= (idx == N);
            end
        end
    end
endmodule : nct_board_model
`default_nettype wire

//--- verif/nct_chain_test_tb.sv
// Purpose : Self-checking bench for the NAND chain test block
// Assumes : Straps are held steady over reset release
// Notes   : Scoreboard compares every cycle against an integer chain model
`timescale 1ns/10ps
`default_nettype none
module nct_chain_test_tb;
    localparam int unsigned N     = nct_pkg::CHAIN_LEN;
    localparam logic [2:0]  STRAP = 3'h7;  // Code selecting test mode
    logic         mclk_i    = 1'b0;
    logic         rst_b_i   = 1'b0;
    logic [N-1:0] tb_pins   = '1;  // Pins driven by the bench
    logic [N-1:0] mdl_pins;        // Pins driven by the board model
    logic [N-1:0] pins;            // Pins seen by the design
    logic         irq_low   = 1'b1;
    logic         use_mdl   = 1'b0;
    logic         start     = 1'b0;
    logic [1:0]   pace      = 2'h1;
    logic         done;
    logic         fault;
    logic         out_low;
    logic         mode;
    logic         exp_low;  // Expected interrupt pin
    logic         mode_q;   // Expected test mode
    logic         first;    // First edge after reset
    logic [31:0]  rng       = 32'h0000B006;
    int           bad_count = 0;
    int           checked   = 0;
    assign pins = use_mdl ? mdl_pins : tb_pins;
    // ------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------
    initial forever #50 mclk_i = ~mclk_i;
    nct_chain_test #(.TEST_STRAP_CODE(STRAP), .CHAIN_LEN(N)) nct_chain_test_inst (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .chain_pins_i(pins), .normal_irq_low_i(irq_low),
        .interrupt_out_low_o(out_low), .test_mode_o(mode));
    nct_board_model #(.N(N)) nct_board_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .start_i(start), .pace_i(pace), .obs_low_i(out_low), .pins_o(mdl_pins), .done_o(done),
        .fault_o(fault));
    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic chain_nand(input logic [N-1:0] p);
        int z;
        z = 1;
        for (int k = 0; k < N; k++) z = !(z && p[k]);
        if (N % 2 == 1) z = !z;  // Odd length: all-high reads 1
        return z[0];
    endfunction : chain_nand
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            exp_low <= 1'b1;
            mode_q  <= 1'b0;
            first   <= 1'b1;
        end else begin
            exp_low <= mode_q ? chain_nand(pins) : irq_low;
            if (first) mode_q <= ({pins[nct_pkg::POS_PORT2_LED_B], pins[nct_pkg::POS_PORT2_LED_A],
                                   pins[nct_pkg::POS_PORT4_LED_A]} == STRAP);
            first <= 1'b0;
        end
    end
    task automatic check(input logic seen, input logic expv);
        checked++;
        if (seen !== expv) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %b expected %b", $time, seen, expv);
        end
    endtask : check
    // Every settled cycle is compared
    always @(negedge mclk_i) begin
        if (rst_b_i) begin
            check(out_low, exp_low);
            check(mode, mode_q);
        end
    end
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic do_reset(input logic [2:0] code);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        use_mdl <= 1'b0;
        tb_pins <= '1;
        tb_pins[nct_pkg::POS_PORT2_LED_B] <= code[2];
        tb_pins[nct_pkg::POS_PORT2_LED_A] <= code[1];
        tb_pins[nct_pkg::POS_PORT4_LED_A] <= code[0];
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask : do_reset
    // Random pins and interrupt source; straps move too but mode must hold
    task automatic rand_cycles(input int n);
        logic [31:0] a;
        repeat (n) begin
            rng = xs(rng);
            a = rng;
            rng = xs(rng);
            tb_pins <= {a[16:0], rng};
            irq_low <= a[31];
            @(posedge mclk_i);
        end
    endtask : rand_cycles
    task automatic sweep(input logic [1:0] p, input logic expf);
        start <= 1'b1;
        pace  <= p;
        use_mdl <= 1'b1;
        @(posedge mclk_i);
        start <= 1'b0;
        @(negedge mclk_i);
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge mclk_i);
        check(done, 1'b1);
        check(fault, expf);
        @(posedge mclk_i);
    endtask : sweep
    task automatic final_report;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (5000) @(posedge mclk_i);
        bad_count++;
        final_report();
    end
    initial begin
        for (int c = 0; c < 8; c++) begin
            do_reset(c[2:0]);
            @(negedge mclk_i);
            check(mode, c[2:0] == STRAP);
            @(posedge mclk_i);
            rand_cycles(20);
        end
        sweep(2'h1, 1'b0);
        sweep(2'h3, 1'b0);
        // Outside test mode the pin ignores the chain, so the board must see faults
        irq_low <= 1'b1;
        do_reset(3'h0);
        sweep(2'h3, 1'b1);
        final_report();
    end
endmodule : nct_chain_test_tb
`default_nettype wire
